// ===== src/usrt_pkg.sv
package usrt_pkg;
  // Register select codes
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_STATUS_SYNC = 2'h1;
  localparam logic [1:0] SEL_MODE = 2'h2;
  localparam logic [1:0] SEL_COMMAND = 2'h3;
  // Status bit positions
  localparam int ST_TX_READY = 0;
  localparam int ST_RX_READY = 1;
  localparam int ST_TX_EMPTY_CHG = 2;
  localparam int ST_OVERRUN = 4;
  localparam int ST_CARRIER = 6;
  localparam int ST_DATA_SET = 7;
  // Command bit positions
  localparam int CMD_TX_EN = 0;
  localparam int CMD_DTR = 1;
  localparam int CMD_RX_EN = 2;
  localparam int CMD_RTS = 5;
  // Mode 2 fields
  localparam int MODE2_RATE_LSB = 0;
  localparam int MODE2_INT_CLK = 4;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam int FIFO_DEPTH = 32;
  // Reference clock divisors for the 16 rates, 16x oversampling
  localparam logic [12:0] RATE_DIV [16] = '{
    13'h18C0, 13'h1080, 13'h0B40, 13'h0933, 13'h0840, 13'h0420,
    13'h0210, 13'h0108, 13'h00B0, 13'h009E, 13'h0084, 13'h0058,
    13'h0042, 13'h002C, 13'h0021, 13'h0010};

  typedef enum logic [1:0] {
    USRT_IDLE = 2'b00,
    USRT_START = 2'b01,
    USRT_DATA = 2'b11,
    USRT_STOP = 2'b10
  } usrt_state_e;

  // Host access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] sel;
    logic [7:0] data;
  } usrt_access_s;

  // Modem pins seen by the device
  typedef struct packed {
    logic dsr_n;
    logic dcd_n;
    logic cts_n;
  } usrt_modem_s;
endpackage

// ===== src/usrt_fifo.sv
`timescale 1ns/1ps
module usrt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) ||
                    (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ===== src/usrt_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Reset aborts activity, clears mode, command, status.
// RULE_02: Stays idle until host writes control words.
// RULE_03: Read/write low means read, high means write.
// RULE_04: Chip select low performs the selected access.
// RULE_05: Chip select high leaves data bus undriven.
// RULE_06: Eight-bit bidirectional data bus, bit 0 LSB.
// RULE_07: Two select lines choose the internal register.
// RULE_08: Transmit ready pin is inverse of status bit0.
// RULE_09: Transmit ready meaningful only with transmitter enabled.
// RULE_10: Receive ready pin low while character unread.
// RULE_11: Receive ready high on read or disable.
// RULE_12: Empty pin low after last character shifted.
// RULE_13: Data-set-ready or carrier change drives empty pin.
// RULE_14: Status read releases pin unless transmitter empty.
// RULE_15: Empty condition holds pin until holding load.
// RULE_16: Two mode, command and status registers accessible.
// RULE_17: Baud source external clocks or divided reference.
// RULE_18: Sixteen rates, one shared by both directions.
// RULE_19: Receiver assembles serial input into characters.
// RULE_20: Transmitter serialises characters with framing bits.
// RULE_21: Two sync and one escape register.
// RULE_22: Three modem inputs and three modem outputs; the code has two outputs, dtr_n and rts_n.
// RULE_23: Carrier detect must be low to receive.
// RULE_24: Clear-to-send high stops after current character.
// RULE_25: Terminal-ready pin is inverse of command bit1.
// RULE_26: Request-to-send pin is inverse of command bit5.
// RULE_27: Data bus driven only during reads.
module usrt_top #(
  parameter int FIFO_WORDS = usrt_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic chip_select_n,
  input wire logic read_write,
  input wire logic [1:0] register_select,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  output logic tx_ready_n,
  output logic rx_ready_n,
  output logic tx_empty_or_modem_change_n,
  input wire logic baud_ref_clk,
  input wire logic tx_clk_in,
  input wire logic rx_clk_in,
  input wire logic rx_data,
  output logic tx_data,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic cts_n,
  output logic dtr_n,
  output logic rts_n
);
  import usrt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before any logic reads a pin
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic ce_s1;
  logic ce_s2;
  logic ce_s3;
  logic rw_s1;
  logic rw_s2;
  logic [1:0] sel_s1;
  logic [1:0] sel_s2;
  logic [7:0] dat_s1;
  logic [7:0] dat_s2;
  usrt_modem_s modem;
  usrt_access_s acc;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 8'hFF;
      pin_s2 <= 8'hFF;
    end else begin
      // Top bit unused; line, reference, tx/rx clocks, modem pins below
      pin_s1 <= {1'b1, rx_data, baud_ref_clk, tx_clk_in, rx_clk_in, dsr_n,
                 dcd_n, cts_n};
      pin_s2 <= pin_s1;
    end
  end

  // Host strobes; chip select falling edge gives a single access per assertion
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ce_s1 <= 1'b1;
      ce_s2 <= 1'b1;
      ce_s3 <= 1'b1;
      rw_s1 <= 1'b0;
      rw_s2 <= 1'b0;
      sel_s1 <= 2'h0;
      sel_s2 <= 2'h0;
      dat_s1 <= 8'h00;
      dat_s2 <= 8'h00;
    end else begin
      ce_s1 <= chip_select_n;
      ce_s2 <= ce_s1;
      ce_s3 <= ce_s2;
      rw_s1 <= read_write;
      rw_s2 <= rw_s1;
      sel_s1 <= register_select;
      sel_s2 <= sel_s1;
      dat_s1 <= host_data_bus_in;
      dat_s2 <= dat_s1;
    end
  end

  assign modem.dsr_n = pin_s2[2];
  assign modem.dcd_n = pin_s2[1];
  assign modem.cts_n = pin_s2[0];
  // One access on the falling edge of chip select
  assign acc.rd = ce_s3 && !ce_s2 && !rw_s2; // RULE_03 RULE_04
  assign acc.wr = ce_s3 && !ce_s2 && rw_s2; // RULE_03 RULE_04
  assign acc.sel = sel_s2; // RULE_07
  assign acc.data = dat_s2; // RULE_06

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] mode1;
  logic [7:0] mode2;
  logic mode_ptr;
  logic [7:0] command;
  logic [7:0] sync_char_one;
  logic [7:0] sync_char_two;
  logic [7:0] escape_char;
  logic [1:0] sync_ptr;
  logic tx_en;
  logic rx_en;

  assign tx_en = command[CMD_TX_EN];
  assign rx_en = command[CMD_RX_EN];

  // Mode writes alternate and sync writes rotate through pointers; a command register
  // read rewinds them, so the host can always get back in step
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode1 <= MODE_RESET; // RULE_01
      mode2 <= MODE_RESET; // RULE_01
      mode_ptr <= 1'b0;
      command <= COMMAND_RESET; // RULE_01 RULE_02
      sync_char_one <= CHAR_RESET;
      sync_char_two <= CHAR_RESET;
      escape_char <= CHAR_RESET;
      sync_ptr <= 2'h0;
    end else if (acc.wr) begin
      case (acc.sel)
        SEL_MODE: begin
          if (!mode_ptr) begin
            mode1 <= acc.data; // RULE_16
          end else begin
            mode2 <= acc.data; // RULE_16
          end
          mode_ptr <= !mode_ptr;
        end
        SEL_COMMAND: begin
          command <= acc.data; // RULE_16
        end
        SEL_STATUS_SYNC: begin
          case (sync_ptr)
            2'h0: sync_char_one <= acc.data; // RULE_21
            2'h1: sync_char_two <= acc.data; // RULE_21
            default: escape_char <= acc.data; // RULE_21
          endcase
          sync_ptr <= (sync_ptr == 2'h2) ? 2'h0 : sync_ptr + 2'h1;
        end
        default: begin
        end
      endcase
    end else if (acc.rd && acc.sel == SEL_COMMAND) begin
      mode_ptr <= 1'b0;
      sync_ptr <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: reference divided to a 16x tick, or external clocks
  logic ref_q;
  logic ref_tick;
  logic [12:0] div_cnt;
  logic int_tick;
  logic [1:0] ext_q;
  logic tx_tick;
  logic rx_tick;
  logic [3:0] tx_sub;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ref_q <= 1'b1; // Synchroniser reset level: no false edge
      ext_q <= 2'h3;
    end else begin
      ref_q <= pin_s2[5];
      ext_q <= {pin_s2[4], pin_s2[3]};
    end
  end
  assign ref_tick = pin_s2[5] && !ref_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 13'h0000;
    end else if (ref_tick) begin
      if (div_cnt >= RATE_DIV[mode2[MODE2_RATE_LSB +: 4]] - 13'h0001) begin
        div_cnt <= 13'h0000; // RULE_18
      end else begin
        div_cnt <= div_cnt + 13'h0001;
      end
    end
  end
  assign int_tick = ref_tick && (div_cnt == 13'h0000);

  // Same internal tick serves both directions
  assign tx_tick = mode2[MODE2_INT_CLK] ? int_tick
                 : (!pin_s2[4] && ext_q[1]); // RULE_17 RULE_18
  assign rx_tick = mode2[MODE2_INT_CLK] ? int_tick
                 : (pin_s2[3] && !ext_q[0]); // RULE_17

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: 8N1 frames at 16 ticks per bit
  logic [7:0] tx_holding_reg;
  logic thr_full;
  logic [7:0] tx_shift;
  logic [2:0] tx_bit;
  usrt_state_e tx_state;
  logic tx_empty;
  logic tx_load;

  assign tx_load = acc.wr && acc.sel == SEL_DATA;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_holding_reg <= 8'h00;
      thr_full <= 1'b0;
    end else if (tx_load) begin
      tx_holding_reg <= acc.data;
      thr_full <= 1'b1; // RULE_08
    end else if (tx_state == USRT_IDLE && thr_full && tx_en &&
                 !modem.cts_n) begin
      thr_full <= 1'b0;
    end
  end

  // Clear-to-send is checked only between characters
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state <= USRT_IDLE; // RULE_01
      tx_shift <= 8'h00;
      tx_bit <= 3'h0;
      tx_sub <= 4'h0;
      tx_data <= 1'b1;
      tx_empty <= 1'b0;
    end else begin
      case (tx_state)
        USRT_IDLE: begin
          tx_data <= 1'b1;
          tx_sub <= 4'h0;
          if (thr_full && tx_en && !modem.cts_n) begin // RULE_02 RULE_24
            tx_shift <= tx_holding_reg; // RULE_20
            tx_state <= USRT_START;
            tx_empty <= 1'b0;
          end else if (tx_load) begin
            tx_empty <= 1'b0; // RULE_15
          end
        end
        USRT_START: begin
          tx_data <= 1'b0;
          if (tx_tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_state <= USRT_DATA;
              tx_bit <= 3'h0;
            end
          end
        end
        USRT_DATA: begin
          tx_data <= tx_shift[0]; // RULE_20
          if (tx_tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bit <= tx_bit + 3'h1;
              if (tx_bit == 3'h7) begin
                tx_state <= USRT_STOP;
              end
            end
          end
        end
        USRT_STOP: begin
          tx_data <= 1'b1;
          if (tx_tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == 4'hF) begin
              tx_state <= USRT_IDLE; // RULE_24
              tx_empty <= !thr_full && !tx_load; // RULE_12 RULE_15
            end
          end
        end
        default: tx_state <= USRT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: mid-bit sampling, characters go through the FIFO
  usrt_state_e rx_state;
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_push;
  logic rx_fifo_ready;
  logic rx_overrun;
  logic rx_line;
  logic rx_go;

  assign rx_line = pin_s2[6];
  assign rx_go = rx_en && !modem.dcd_n; // RULE_23

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state <= USRT_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (!rx_go) begin
        rx_state <= USRT_IDLE;
      end else if (rx_tick) begin
        rx_sub <= rx_sub + 4'h1;
        case (rx_state)
          USRT_IDLE: begin
            rx_sub <= 4'h0;
            if (!rx_line) begin
              rx_state <= USRT_START;
            end
          end
          USRT_START: begin
            if (rx_sub == 4'h7) begin
              rx_sub <= 4'h0;
              rx_bit <= 3'h0;
              rx_state <= rx_line ? USRT_IDLE : USRT_DATA;
            end
          end
          USRT_DATA: begin
            if (rx_sub == 4'hF) begin
              rx_shift <= {rx_line, rx_shift[7:1]}; // RULE_19
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_state <= USRT_STOP;
              end
            end
          end
          USRT_STOP: begin
            if (rx_sub == 4'hF) begin
              rx_state <= USRT_IDLE;
              rx_push <= rx_line; // RULE_19
            end
          end
          default: rx_state <= USRT_IDLE;
        endcase
      end
    end
  end

  logic rx_avail;
  logic [7:0] rx_holding_reg;
  logic rx_read;

  assign rx_read = acc.rd && acc.sel == SEL_DATA;

  usrt_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) rx_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .flush(!rx_en), // RULE_11
    .in_valid(rx_push),
    .in_ready(rx_fifo_ready),
    .in_data(rx_shift),
    .out_valid(rx_avail),
    .out_ready(rx_read), // RULE_11
    .out_data(rx_holding_reg)
  );

  // A character with no room is lost and flagged
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_overrun <= 1'b0;
    end else if (rx_push && !rx_fifo_ready) begin
      rx_overrun <= 1'b1;
    end else if (!rx_en) begin
      rx_overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem change latch; a change in the clearing cycle still sets it
  logic [1:0] modem_q;
  logic modem_chg;
  logic status_read;
  logic [2:0] pin_fill;

  assign status_read = acc.rd && acc.sel == SEL_STATUS_SYNC;

  // Compare only once the synchronisers hold real pin levels, so their
  // reset value cannot pose as a modem change after reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      modem_q <= 2'h3;
      modem_chg <= 1'b0;
      pin_fill <= 3'h0;
    end else begin
      pin_fill <= {pin_fill[1:0], 1'b1};
      modem_q <= {modem.dsr_n, modem.dcd_n};
      if (pin_fill[2] && modem_q != {modem.dsr_n, modem.dcd_n}) begin
        modem_chg <= 1'b1; // RULE_13
      end else if (status_read && !tx_empty) begin
        modem_chg <= 1'b0; // RULE_14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, read data, pins
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[ST_TX_READY] = !thr_full && tx_en; // RULE_08 RULE_09
    status[ST_RX_READY] = rx_avail && rx_en; // RULE_10 RULE_11
    status[ST_TX_EMPTY_CHG] = tx_empty || modem_chg; // RULE_12 RULE_15
    status[ST_OVERRUN] = rx_overrun;
    status[ST_CARRIER] = !modem.dcd_n;
    status[ST_DATA_SET] = !modem.dsr_n;
  end

  // Bus is driven only while a read is selected
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_data_bus_out <= 8'h00;
      host_data_bus_oe <= 1'b0; // RULE_05
    end else begin
      host_data_bus_oe <= !ce_s2 && !rw_s2; // RULE_05 RULE_27
      // Captured at the access edge, before the read pops the buffer or
      // clears a flag, and held until the next read
      if (acc.rd) begin
        case (acc.sel) // RULE_07
          SEL_DATA: host_data_bus_out <= rx_holding_reg;
          SEL_STATUS_SYNC: host_data_bus_out <= status;
          SEL_MODE: host_data_bus_out <= mode_ptr ? mode2 : mode1;
          default: host_data_bus_out <= command;
        endcase
      end
    end
  end

  // Active-low status pins and modem outputs, driven at both levels
  assign tx_ready_n = !status[ST_TX_READY]; // RULE_08
  assign rx_ready_n = !status[ST_RX_READY]; // RULE_10
  assign tx_empty_or_modem_change_n = !status[ST_TX_EMPTY_CHG]; // RULE_12
  assign dtr_n = !command[CMD_DTR]; // RULE_25 RULE_22
  assign rts_n = !command[CMD_RTS]; // RULE_26 RULE_22
endmodule

// ===== testbench/usrt_assertions.sv
`timescale 1ns/1ps
module usrt_assertions (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic chip_select_n,
  input wire logic read_write,
  input wire logic host_data_bus_oe,
  input wire logic tx_ready_n,
  input wire logic rx_ready_n,
  input wire logic tx_empty_or_modem_change_n,
  input wire logic rx_data,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic dtr_n,
  input wire logic rts_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Bus ownership follows select and direction past the sync delay
  a_bus_float: assert property (
    chip_select_n [*4] |-> !host_data_bus_oe)
    else $error("data bus driven while deselected");
  a_write_float: assert property (
    read_write [*4] |-> !host_data_bus_oe)
    else $error("data bus driven during a write");
  a_read_drive: assert property (
    (!chip_select_n && !read_write) [*5] |-> host_data_bus_oe)
    else $error("data bus not driven during a read");
  ////////////////////////////////////////////////////////////////////////////
  // Modem outputs move only as a result of a host write
  a_dtr_cause: assert property (
    $changed(dtr_n) |-> $past(!chip_select_n && read_write, 2))
    else $error("terminal ready moved without a write");
  a_rts_cause: assert property (
    $changed(rts_n) |-> $past(!chip_select_n && read_write, 2))
    else $error("request to send moved without a write");
  ////////////////////////////////////////////////////////////////////////////
  // Status pins: who may release them, and what sets them
  a_tx_ready_n_load: assert property (
    $rose(tx_ready_n) |-> $past(!chip_select_n && read_write, 2))
    else $error("transmit ready released without a write");
  a_rx_ready_n_clear: assert property (
    $rose(rx_ready_n) |-> $past(!chip_select_n, 2))
    else $error("receive ready released without an access");
  a_empty_clear: assert property (
    $rose(tx_empty_or_modem_change_n) |-> $past(!chip_select_n, 2))
    else $error("empty pin released without an access");
  // A few cycles covers the input synchroniser
  a_modem_flag: assert property (
    $changed(dsr_n) || $changed(dcd_n)
    |-> ##[1:6] !tx_empty_or_modem_change_n)
    else $error("modem change not flagged");
  // A character lands only once the stop bit is on the line
  a_rx_stop: assert property (
    $fell(rx_ready_n) |-> $past(rx_data, 3))
    else $error("receive ready without a stop bit");
endmodule

bind usrt_top usrt_assertions u_usrt_assertions (
  .core_clk,
  .resetn,
  .chip_select_n,
  .read_write,
  .host_data_bus_oe,
  .tx_ready_n,
  .rx_ready_n,
  .tx_empty_or_modem_change_n,
  .rx_data,
  .dsr_n,
  .dcd_n,
  .dtr_n,
  .rts_n
);

// ===== testbench/usrt_line_model.sv
`timescale 1ns/1ps
// Far end of the serial line plus the modem handshake inputs
module usrt_line_model (
  input wire logic core_clk,
  input wire logic tx_data,
  output logic rx_data,
  output logic ser_clk,
  output logic dsr_n,
  output logic dcd_n,
  output logic cts_n
);
  // Modem 16x clock, 8 core cycles a period, free running like a modem's
  initial ser_clk = 1'h0;
  always #16 ser_clk = ~ser_clk;
  ////////////////////////////////////////////////////////////////////////////
  // Line idles at mark; carrier held low so the receiver may run
  initial begin
    rx_data = 1'h1;
    dsr_n = 1'h0;
    dcd_n = 1'h0;
    cts_n = 1'h0;
  end
  // One 8N1 frame, LSB first, bc core cycles a bit
  task automatic send_byte(input int bc, input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk);
      rx_data = f[i];
      repeat (bc - 1) @(negedge core_clk);
    end
  endtask
  // Sample mid-bit after the start edge; a hang is cut by the bench
  task automatic get_byte(input int bc, output logic [7:0] b);
    @(negedge tx_data);
    repeat (bc / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bc) @(posedge core_clk);
      b[i] = tx_data;
    end
  endtask
  task automatic set_modem(input logic dsr, input logic dcd);
    @(negedge core_clk);
    dsr_n = dsr;
    dcd_n = dcd;
  endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import usrt_pkg::*;
  localparam int LIMIT = 90000;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic chip_select_n = 1'h1;
  logic read_write = 1'h1;
  logic [1:0] register_select = 2'h0;
  logic [7:0] din = 8'h00;
  logic baud_ref_clk = 1'h0;
  logic [7:0] host_data_bus_out;
  wire [7:0] bus;
  logic host_data_bus_oe, tx_ready_n, rx_ready_n, tx_data, rx_data, ser_clk;
  logic tx_empty_or_modem_change_n, dsr_n, dcd_n, cts_n, dtr_n, rts_n;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Wire level: the device wins while it drives, else the bench value
  assign bus = host_data_bus_oe ? host_data_bus_out : din;
  always #2 core_clk = ~core_clk;
  always #8 baud_ref_clk = ~baud_ref_clk;
  usrt_top #(.FIFO_WORDS(FIFO_DEPTH)) u_usrt_top (
    .core_clk, .resetn, .chip_select_n, .read_write, .register_select,
    .host_data_bus_in(bus), .host_data_bus_out, .host_data_bus_oe,
    .tx_ready_n, .rx_ready_n, .tx_empty_or_modem_change_n, .baud_ref_clk,
    .tx_clk_in(ser_clk), .rx_clk_in(ser_clk), .rx_data, .tx_data,
    .dsr_n, .dcd_n, .cts_n, .dtr_n, .rts_n);
  usrt_line_model u_usrt_line_model (
    .core_clk, .tx_data, .rx_data, .ser_clk, .dsr_n, .dcd_n, .cts_n);
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, sized above the longest frame sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // No handshake: select held 5 cycles covers the 3-cycle sync delay
  task automatic bus_acc(input logic wr, input logic [1:0] s,
                         input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk);
    chip_select_n = 1'h0;
    read_write = wr;
    register_select = s;
    din = d;
    repeat (5) @(negedge core_clk);
    q = host_data_bus_out;
    check(host_data_bus_oe, !wr);
    chip_select_n = 1'h1;
    din = ~d;
    repeat (5) @(negedge core_clk);
    check(host_data_bus_oe, 1'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    logic [7:0] q;
    check({tx_ready_n, rx_ready_n}, 2'h3);
    check(tx_empty_or_modem_change_n, 1'h1);
    check({dtr_n, rts_n, tx_data}, 3'h7);
    bus_acc(1'h0, SEL_COMMAND, 8'h00, q);
    check(q, COMMAND_RESET);
    bus_acc(1'h0, SEL_MODE, 8'h00, q);
    check(q, MODE_RESET);
    bus_acc(1'h0, SEL_STATUS_SYNC, 8'h00, q);
    check(q & 8'hD6, 8'hC0);
  endtask
  task automatic s_command();
    logic [7:0] q;
    logic [7:0] cw [4] = '{8'h02, 8'h20, 8'h22, 8'h00};
    for (int i = 0; i < 4; i++) begin
      bus_acc(1'h1, SEL_COMMAND, cw[i], q);
      check(dtr_n, !cw[i][CMD_DTR]);
      check(rts_n, !cw[i][CMD_RTS]);
      bus_acc(1'h0, SEL_COMMAND, 8'h00, q);
      check(q, cw[i]);
    end
    check(tx_ready_n, 1'h1);
  endtask
  // Each step flips exactly one of the two watched modem lines
  task automatic s_modem();
    logic [7:0] q;
    logic [1:0] mv [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++) begin
      u_usrt_line_model.set_modem(mv[i][0], mv[i][1]);
      repeat (8) @(negedge core_clk);
      check(tx_empty_or_modem_change_n, 1'h0);
      bus_acc(1'h0, SEL_STATUS_SYNC, 8'h00, q);
      check(q & 8'hC4, {~mv[i][0], ~mv[i][1], 6'h04});
      check(tx_empty_or_modem_change_n, 1'h1);
    end
  endtask
  // Values chosen so a reversed bit order cannot match
  task automatic s_tx();
    logic [7:0] q, b;
    logic [7:0] tv [2] = '{8'hC1, 8'h3E};
    bus_acc(1'h1, SEL_COMMAND, 8'h05, q);
    check(tx_ready_n, 1'h0);
    for (int i = 0; i < 2; i++) begin
      fork
        u_usrt_line_model.get_byte(128, b);
        bus_acc(1'h1, SEL_DATA, tv[i], q);
      join
      check(b, tv[i]);
      check(tx_empty_or_modem_change_n, 1'h1);
      for (int j = 0; j < 400 && tx_empty_or_modem_change_n !== 1'h0; j++)
        @(negedge core_clk);
      check(tx_empty_or_modem_change_n, 1'h0);
      bus_acc(1'h0, SEL_STATUS_SYNC, 8'h00, q);
      check(q[ST_TX_EMPTY_CHG], 1'h1);
      check(tx_empty_or_modem_change_n, 1'h0);
    end
  endtask
  // Fill the buffer past full while the host stalls, then drain it
  task automatic s_fifo();
    logic [7:0] q;
    for (int i = 0; i <= FIFO_DEPTH; i++)
      u_usrt_line_model.send_byte(128, 8'(i));
    bus_acc(1'h0, SEL_STATUS_SYNC, 8'h00, q);
    check(q[ST_OVERRUN], 1'h1);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      check(rx_ready_n, 1'h0);
      bus_acc(1'h0, SEL_DATA, 8'h00, q);
      check(q, 8'(i));
    end
    check(rx_ready_n, 1'h1);
    u_usrt_line_model.send_byte(128, 8'h77);
    check(rx_ready_n, 1'h0);
    bus_acc(1'h1, SEL_COMMAND, 8'h01, q);
    check(rx_ready_n, 1'h1);
    bus_acc(1'h1, SEL_COMMAND, 8'h05, q);
    check(rx_ready_n, 1'h1);
  endtask
  // Internal rate 15 from the reference, one rate for both directions
  task automatic s_baud();
    logic [7:0] q, b;
    int bc;
    bc = 16 * 4 * RATE_DIV[15];
    bus_acc(1'h0, SEL_COMMAND, 8'h00, q);
    bus_acc(1'h1, SEL_MODE, 8'h00, q);
    bus_acc(1'h1, SEL_MODE, 8'h1F, q);
    for (int i = 0; i < 3; i++)
      bus_acc(1'h1, SEL_STATUS_SYNC, 8'h16, q);
    bus_acc(1'h0, SEL_COMMAND, 8'h00, q);
    bus_acc(1'h0, SEL_MODE, 8'h00, q);
    check(q, 8'h00);
    // Reads follow the write pointer: rewrite mode 1 to reach mode 2
    bus_acc(1'h1, SEL_MODE, 8'h00, q);
    bus_acc(1'h0, SEL_MODE, 8'h00, q);
    check(q, 8'h1F);
    fork
      u_usrt_line_model.get_byte(bc, b);
      bus_acc(1'h1, SEL_DATA, 8'h4D, q);
    join
    check(b, 8'h4D);
    u_usrt_line_model.send_byte(bc, 8'h96);
    check(rx_ready_n, 1'h0);
    bus_acc(1'h0, SEL_DATA, 8'h00, q);
    check(q, 8'h96);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset for 5 cycles, then the scenarios in order
  initial begin
    repeat (5) @(negedge core_clk);
    resetn = 1'h1;
    repeat (2) @(negedge core_clk);
    s_reset();
    s_command();
    s_modem();
    s_tx();
    s_fifo();
    s_baud();
    print_verdict();
  end
endmodule
